// ---- src/ext_mem_wait_pkg.sv ----
// types for the external memory wait-state block
package ext_mem_wait_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_WAIT,
    ST_DATA,
    ST_DATA_WAIT
  } bus_state_t;

  // strobe outputs and the busy flag travelling together
  typedef struct packed {
    logic addr_strobe_n;
    logic data_strobe_n;
    logic second_strobe_n;
    logic busy;
  } strobe_bits_t;
endpackage

// ---- src/ext_mem_wait_regs.svh ----
// register offsets, field positions, reset values, write masks and counter constants for the wait-state block
`ifndef EXT_MEM_WAIT_REGS_SVH
`define EXT_MEM_WAIT_REGS_SVH
`define EMC2_OFFSET 8'hF6
`define SWC_OFFSET 8'hFC
`define EMC2_RESET 8'h1F
`define SWC_RESET 8'h7F
`define EMC2_WMASK 8'h7F
`define SWC_WMASK 8'h7F
`define ENCS_BIT 6
`define REMAP_BIT 5
`define MEMORY_SELECT_BIT 4
`define LAS_LSB 2
`define UAS_LSB 0
`define WDG_BIT 6
`define UDS_LSB 3
`define LDS_LSB 0
`define BLOCK_BIT 21
`define ZERO_CNT 3'h0
`define ONE_CNT 3'h1
`define DPR_PAGE 6'h15
`endif

// ---- src/ext_mem_wait_state_config.sv ----
// external memory wait-state configuration and bus cycle sequencer
// Behaviour
// - Save clear: isr replaces csr, no push
// - Save set: push csr, load from isr
// - Save set: return pops csr too
// - Remap swaps data page regs with ports
// - Lower address strobe stretch 0-3, reset 3
// - Upper address strobe stretch 0-3, reset 3
// - Wait control bit 7 reads zero
// - Clearing watchdog_enable selects watchdog mode
// - Upper data strobe stretch 0-7, reset 7
// - Lower data strobe stretch 0-7, reset 7
// - Stretch counted in internal clock cycles
// - Address bit 21 selects lower/upper block
// - Wait input adds cycles per phase
// - Second strobe serves lower block only
//
// The implementer's own choice: the address-and-strobe port.
`include "ext_mem_wait_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module ext_mem_wait_state_config (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // interrupt stacking context from the core
  input wire logic int_entry_in,
  input wire logic int_return_in,
  input wire logic in_service_in,
  input wire logic [7:0] code_segment_in,
  input wire logic [7:0] interrupt_segment_in,
  input wire logic [7:0] popped_segment_in,
  // external access request
  input wire logic access_req_in,
  input wire logic [21:0] access_addr_in,
  input wire logic wait_enable_in,
  input wire logic wait_n_in,
  input wire logic second_strobe_enable_in,
  // stacking and segment results
  output logic push_segment_out,
  output logic pop_segment_out,
  output logic [7:0] active_segment_out,
  // configuration to the rest of the chip
  output logic data_page_remap_out,
  output logic [5:0] data_page_regs_page_out,
  output logic watchdog_mode_out,
  // external strobes
  output logic address_strobe_n_out,
  output logic data_strobe_n_out,
  output logic second_data_strobe_n_out,
  output logic access_done_out
);
  // register port timing
  //   a write lands on the edge that samples the strobe
  //   a read answers one cycle later, then returns to zero
  //   the zero idle value lets software or glue logic or-merge ports
  //   unmapped addresses read zero
  //   the slave never stalls, so there is no ready signal
  //
  // control register two
  //   bit 7 reserved, never stored
  //   bit 6 code segment save enable
  //   bit 5 data page remap
  //   bit 4 memory select, kept only for readback
  //   bits 3:2 lower address strobe stretch
  //   bits 1:0 upper address strobe stretch
  //   writes while in service are dropped
  //   dropping is a choice: silently ignoring beats corrupting the map
  //
  // strobe wait control register
  //   bit 7 reserved, forced low
  //   bit 6 watchdog enable, low selects watchdog mode
  //   bits 5:3 upper data strobe stretch
  //   bits 2:0 lower data strobe stretch
  //   reset gives the slowest bus; software should trim it
  //
  // interrupt stacking
  //   entry always moves the active segment to the handler segment
  //   with save set a push pulse asks the core to stack the segment
  //   with save clear nothing extra is pushed, faster entry
  //   return with save set restores the popped segment
  //   return with save clear goes back to the live code segment
  //   push and pop pulses follow the entry and return inputs one cycle later, for as long as those are held
  //   limitation: nested entries are not counted here
  //   the core is trusted to pair entries and returns
  //
  // external access sequencer
  //   idle: waits for a request, latches the block
  //   address phase: strobe low for one plus its stretch
  //   data phase: strobe low for one plus its stretch
  //   the wait input holds the current phase one cycle per sample
  //   wait cycles come first, stretch counts after them
  //   done pulses on the edge that raises the data strobe
  //   requests during an access are ignored
  //   the block is latched at the request so a moving address
  //   cannot switch strobes in the middle of a cycle
  //
  // second data strobe
  //   only lower block accesses use it when enabled
  //   the main data strobe then stays high for the whole cycle
  //   upper block accesses leave it high
  //   both strobes are never low together
  //
  // timing base
  //   every stretch count steps once per system clock
  //   this clock stands for the internal clock, never the cpu clock
  //   a slower cpu clock therefore does not lengthen the strobes
  //
  // outputs
  //   every output comes from a flip-flop, so no glitches reach pins
  //   config outputs lag the register by one cycle
  //   the lag is harmless: software changes them rarely
  //
  // hazards
  //   changing stretch fields during an access takes effect
  //   for the address phase at the next request only
  //   the data stretch is chosen as the address phase ends
  //   so a write in that window may give a mixed cycle
  //   software should reconfigure only while the bus is idle
  logic [7:0] ctl2_ff;
  logic [7:0] wctl_ff;
  logic [7:0] rdata_ff;
  logic [7:0] seg_ff;
  logic push_ff;
  logic pop_ff;
  logic in_seg_ff;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic upper_ff;
  logic done_ff;
  ext_mem_wait_pkg::bus_state_t state_ff;
  ext_mem_wait_pkg::bus_state_t nxt_state;
  ext_mem_wait_pkg::strobe_bits_t strobe_ff;
  ext_mem_wait_pkg::strobe_bits_t nxt_strobe;
  logic [7:0] nxt_seg;

  // address decode, a function since both strobes use it
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  wire hit_ctl2 = hit(reg_addr_in, `EMC2_OFFSET);
  wire hit_wctl = hit(reg_addr_in, `SWC_OFFSET);
  // control register two writes inside a service routine are dropped, a safe reading of the caution
  wire wr_ctl2 = reg_wr_in & hit_ctl2 & ~in_service_in;
  wire wr_wctl = reg_wr_in & hit_wctl;
  // bit 7 never stored; memory_select kept as written for software to read
  wire [7:0] ctl2_next = reg_wdata_in & `EMC2_WMASK;
  wire [7:0] wctl_next = reg_wdata_in & `SWC_WMASK;
  wire [7:0] rd_mux = hit_ctl2 ? ctl2_ff : (hit_wctl ? wctl_ff : 8'h00);

  // field views
  wire save_en = ctl2_ff[`ENCS_BIT];
  wire [1:0] las = ctl2_ff[`LAS_LSB +: 2];
  wire [1:0] uas = ctl2_ff[`UAS_LSB +: 2];
  wire [2:0] uds = wctl_ff[`UDS_LSB +: 3];
  wire [2:0] lds = wctl_ff[`LDS_LSB +: 3];
  wire req_upper = access_addr_in[`BLOCK_BIT];
  wire [2:0] as_stretch = req_upper ? {1'b0, uas} : {1'b0, las};
  wire [2:0] ds_stretch = upper_ff ? uds : lds;
  wire waiting = wait_enable_in & ~wait_n_in;

  // register file
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctl2_ff <= `EMC2_RESET;
      wctl_ff <= `SWC_RESET;
      rdata_ff <= 8'h00;
    end else begin
      if (wr_ctl2) ctl2_ff <= ctl2_next;
      if (wr_wctl) wctl_ff <= wctl_next;
      rdata_ff <= reg_rd_in ? rd_mux : 8'h00;
    end
  end

  // segment selection on interrupt entry and return
  always_comb begin
    nxt_seg = seg_ff;
    if (int_entry_in) begin
      nxt_seg = interrupt_segment_in;
    end else if (int_return_in) begin
      nxt_seg = save_en ? popped_segment_in : code_segment_in;
    end else if (!in_seg_ff) begin
      nxt_seg = code_segment_in;
    end
  end

  // stacking control; without save the isr stays in one segment
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      seg_ff <= 8'h00;
      push_ff <= 1'b0;
      pop_ff <= 1'b0;
      in_seg_ff <= 1'b0;
    end else begin
      seg_ff <= nxt_seg;
      push_ff <= int_entry_in & save_en;
      pop_ff <= int_return_in & save_en;
      if (int_entry_in) in_seg_ff <= 1'b1;
      else if (int_return_in) in_seg_ff <= 1'b0;
    end
  end

  // bus cycle sequencer, one step per internal clock cycle
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_strobe = '{1'b1, 1'b1, 1'b1, 1'b1};
    case (state_ff)
      ext_mem_wait_pkg::ST_IDLE: begin
        nxt_strobe.busy = 1'b0;
        if (access_req_in) begin
          nxt_state = ext_mem_wait_pkg::ST_ADDR;
          nxt_cnt = as_stretch;
          nxt_strobe.addr_strobe_n = 1'b0;
          nxt_strobe.busy = 1'b1;
        end
      end
      ext_mem_wait_pkg::ST_ADDR: begin
        nxt_strobe.addr_strobe_n = 1'b0;
        if (waiting) begin
          nxt_state = ext_mem_wait_pkg::ST_ADDR;
        end else if (cnt_ff != `ZERO_CNT) begin
          nxt_cnt = cnt_ff - `ONE_CNT;
        end else begin
          nxt_state = ext_mem_wait_pkg::ST_DATA;
          nxt_cnt = ds_stretch;
          nxt_strobe.addr_strobe_n = 1'b1;
          nxt_strobe.data_strobe_n = second_strobe_enable_in & ~upper_ff;
          nxt_strobe.second_strobe_n = ~(second_strobe_enable_in & ~upper_ff);
        end
      end
      ext_mem_wait_pkg::ST_DATA: begin
        nxt_strobe.data_strobe_n = strobe_ff.data_strobe_n;
        nxt_strobe.second_strobe_n = strobe_ff.second_strobe_n;
        if (waiting) begin
          nxt_state = ext_mem_wait_pkg::ST_DATA;
        end else if (cnt_ff != `ZERO_CNT) begin
          nxt_cnt = cnt_ff - `ONE_CNT; // counted on sys_clk_in
        end else begin
          nxt_state = ext_mem_wait_pkg::ST_IDLE;
          nxt_strobe.data_strobe_n = 1'b1;
          nxt_strobe.second_strobe_n = 1'b1;
          nxt_strobe.busy = 1'b0;
        end
      end
      default: begin
        nxt_state = ext_mem_wait_pkg::ST_IDLE;
        nxt_strobe.busy = 1'b0;
      end
    endcase
  end

  // sequencer registers; block is latched at request so it holds for the cycle
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= ext_mem_wait_pkg::ST_IDLE;
      cnt_ff <= `ZERO_CNT;
      upper_ff <= 1'b0;
      strobe_ff <= '{1'b1, 1'b1, 1'b1, 1'b0};
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      strobe_ff <= nxt_strobe;
      if (state_ff == ext_mem_wait_pkg::ST_IDLE && access_req_in) upper_ff <= req_upper;
      done_ff <= strobe_ff.busy & ~nxt_strobe.busy;
    end
  end

  // config outputs, all registered
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_page_remap_out <= 1'b0;
      data_page_regs_page_out <= `DPR_PAGE;
      watchdog_mode_out <= 1'b0;
    end else begin
      data_page_remap_out <= ctl2_ff[`REMAP_BIT];
      data_page_regs_page_out <= ctl2_ff[`REMAP_BIT] ? 6'h00 : `DPR_PAGE;
      watchdog_mode_out <= ~wctl_ff[`WDG_BIT];
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign push_segment_out = push_ff;
  assign pop_segment_out = pop_ff;
  assign active_segment_out = seg_ff;
  assign address_strobe_n_out = strobe_ff.addr_strobe_n;
  assign data_strobe_n_out = strobe_ff.data_strobe_n;
  assign second_data_strobe_n_out = strobe_ff.second_strobe_n;
  assign access_done_out = done_ff;
endmodule // ext_mem_wait_state_config
`default_nettype wire

// ---- verification/ext_mem_model.sv ----
// external memory model that can stretch each phase through the wait line
`timescale 1ns/100ps
`default_nettype none
module ext_mem_model (
  input wire logic clk_in, as_n_in, ds_n_in, ds2_n_in,
  input wire logic [3:0] waits_in,
  output logic wait_n_out
);
  logic [3:0] cnt_ff, eff_w;
  logic as_q_ff, low_w, start_w;
  // address phase ending restarts the count for the data phase
  assign low_w = !as_n_in || !ds_n_in || !ds2_n_in;
  assign start_w = as_n_in && !as_q_ff;
  assign eff_w = start_w ? 4'h0 : cnt_ff;
  assign wait_n_out = !(low_w && eff_w < waits_in);
  // phase cycle counter
  always_ff @(posedge clk_in) begin
    as_q_ff <= as_n_in;
    cnt_ff <= low_w ? eff_w + 4'h1 : 4'h0;
  end
endmodule // ext_mem_model
`default_nettype wire

// ---- verification/mem_wait_chk_sva.sv ----
// port assertions for the wait-state block
`timescale 1ns/100ps
`default_nettype none
module mem_wait_chk (
  input wire logic sys_clk_in, rst_in, reg_rd_in, int_entry_in, int_return_in,
  input wire logic [7:0] reg_rdata_out, interrupt_segment_in, active_segment_out,
  input wire logic push_segment_out, pop_segment_out, data_page_remap_out,
  input wire logic [5:0] data_page_regs_page_out,
  input wire logic data_strobe_n_out, second_data_strobe_n_out, access_done_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_entry;
    int_entry_in;
  endsequence
  // register read port, stacking, remap and strobes
  a_rd_bit7: assert property (reg_rd_in |=> !reg_rdata_out[7]) else $error("bit7 set");
  a_rd_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00) else $error("stray data");
  a_push_cause: assert property (push_segment_out |-> $past(int_entry_in)) else $error("push");
  a_pop_cause: assert property (pop_segment_out |-> $past(int_return_in)) else $error("pop");
  a_seg_load: assert property (s_entry |=> active_segment_out == $past(interrupt_segment_in))
    else $error("segment");
  a_page_map: assert property (data_page_regs_page_out == (data_page_remap_out ? 6'h00 : 6'h15))
    else $error("page");
  a_one_strobe: assert property (!data_strobe_n_out |-> second_data_strobe_n_out)
    else $error("both strobes");
  a_done_pulse: assert property (access_done_out |=> !access_done_out) else $error("done");
  a_done_after: assert property (access_done_out |-> data_strobe_n_out && second_data_strobe_n_out
    && !($past(data_strobe_n_out) && $past(second_data_strobe_n_out)))
    else $error("done timing");
endmodule // mem_wait_chk
bind ext_mem_wait_state_config mem_wait_chk chk_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
  .reg_rd_in(reg_rd_in), .int_entry_in(int_entry_in), .int_return_in(int_return_in),
  .reg_rdata_out(reg_rdata_out), .interrupt_segment_in(interrupt_segment_in),
  .active_segment_out(active_segment_out), .push_segment_out(push_segment_out),
  .pop_segment_out(pop_segment_out), .data_page_remap_out(data_page_remap_out),
  .data_page_regs_page_out(data_page_regs_page_out), .data_strobe_n_out(data_strobe_n_out),
  .second_data_strobe_n_out(second_data_strobe_n_out), .access_done_out(access_done_out));
`default_nettype wire

// ---- verification/tb_ext_mem_wait_state_config.sv ----
// self-checking bench for the wait-state block
`timescale 1ns/100ps
`default_nettype none
module tb_ext_mem_wait_state_config;
  logic sys_clk_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0, req = 1'b0;
  logic ent = 1'b0, ret = 1'b0, svc = 1'b0, second_strobe_enable = 1'b0, push, pop, remap, wdg;
  logic as_n, ds_n, ds2_n, done, wait_n;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, seg;
  logic [21:0] addr = 22'h000000;
  logic [5:0] page;
  logic [3:0] waits = 4'h0;
  int n_errors = 0, checks = 0, cycles = 0;
  ext_mem_wait_state_config dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .int_entry_in(ent),
    .int_return_in(ret), .in_service_in(svc), .code_segment_in(8'h31),
    .interrupt_segment_in(8'h42), .popped_segment_in(8'h53), .access_req_in(req),
    .access_addr_in(addr), .wait_enable_in(1'b1), .wait_n_in(wait_n),
    .second_strobe_enable_in(second_strobe_enable), .push_segment_out(push), .pop_segment_out(pop),
    .active_segment_out(seg), .data_page_remap_out(remap), .data_page_regs_page_out(page),
    .watchdog_mode_out(wdg), .address_strobe_n_out(as_n), .data_strobe_n_out(ds_n),
    .second_data_strobe_n_out(ds2_n), .access_done_out(done));
  ext_mem_model mem_u (.clk_in(sys_clk_in), .as_n_in(as_n), .ds_n_in(ds_n),
    .ds2_n_in(ds2_n), .waits_in(waits), .wait_n_out(wait_n));
  // clock, and a ceiling far above the expected run
  initial forever #50 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) if (++cycles == 5000) begin
    n_errors++;
    results();
  end
  task automatic chk(input string what, input logic [7:0] exp, got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, exp);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge sys_clk_in);
    chk("reg_rdata_out", exp, reg_rdata_out);
  endtask
  // strobe lengths are counted at the falling edge, where they are settled
  task automatic t_acc(input logic [7:0] e2, w, input logic [21:0] a, input logic d2, wt);
    logic [7:0] na, nd, no;
    logic lo, use2;
    int t;
    lo = !a[21];
    use2 = d2 && lo;
    na = 8'h00;
    nd = 8'h00;
    no = 8'h00;
    t = 0;
    second_strobe_enable <= d2;
    waits <= {2'h0, wt, wt};
    wr(8'hF6, e2);
    wr(8'hFC, w);
    @(posedge sys_clk_in);
    addr <= a;
    req <= 1'b1;
    @(posedge sys_clk_in);
    req <= 1'b0;
    while (t < 40 && done !== 1'b1) begin
      @(negedge sys_clk_in);
      t++;
      na += 8'(!as_n);
      nd += 8'(use2 ? !ds2_n : !ds_n);
      no += 8'(use2 ? !ds_n : !ds2_n);
    end
    chk("as_len", 8'(lo ? e2[3:2] : e2[1:0]) + 8'h01 + 8'({wt, wt}), na);
    chk("ds_len", 8'(lo ? w[2:0] : w[5:3]) + 8'h01 + 8'({wt, wt}), nd);
    chk("idle_strobe", 8'h00, no);
  endtask
  task automatic irq(input logic r, p, input logic [7:0] s);
    @(posedge sys_clk_in);
    ent <= !r;
    ret <= r;
    @(posedge sys_clk_in);
    ent <= 1'b0;
    ret <= 1'b0;
    @(negedge sys_clk_in);
    chk("stack_pulse", {7'h00, p}, {7'h00, r ? pop : push});
    chk("active_segment_out", s, seg);
  endtask
  task automatic results();
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rdc(8'hF6, 8'h1F);
    rdc(8'hFC, 8'h7F);
    rdc(8'h00, 8'h00);
    wr(8'hFC, 8'hBF);
    rdc(8'hFC, 8'h3F);
    chk("watchdog_mode_out", 8'h01, {7'h00, wdg});
    wr(8'hF6, 8'h30);
    repeat (2) @(posedge sys_clk_in);
    chk("page", 8'h40, {1'b0, remap, page});
    svc <= 1'b1;
    wr(8'hF6, 8'h1F);
    rdc(8'hF6, 8'h30);
    svc <= 1'b0;
    wr(8'hF6, 8'hDF);
    irq(1'b0, 1'b1, 8'h42);
    irq(1'b1, 1'b1, 8'h53);
    wr(8'hF6, 8'h1F);
    irq(1'b0, 1'b0, 8'h42);
    irq(1'b1, 1'b0, 8'h31);
    t_acc(8'h13, 8'h78, 22'h1FFFFF, 1'b0, 1'b0);
    t_acc(8'h13, 8'h78, 22'h200000, 1'b0, 1'b0);
    t_acc(8'h19, 8'h5D, 22'h000010, 1'b1, 1'b0);
    t_acc(8'h19, 8'h5D, 22'h3FFFFF, 1'b1, 1'b0);
    t_acc(8'h17, 8'h43, 22'h000100, 1'b0, 1'b1);
    results();
  end
endmodule // tb_ext_mem_wait_state_config
`default_nettype wire
